/* File: logic/reset_bank_defines.svh */
`ifndef RESET_BANK_DEFINES_SVH
`define RESET_BANK_DEFINES_SVH

// Register placement
`define SYSCTL_BASE_ADDR 32'h400f_e000
`define PERIPH_RESET_CTL_B_OFFSET 12'h044
`define PERIPH_RESET_CTL_B_RESET 32'h0000_0000
`define APB_ADDR_W 12

// Field positions
`define COMPARATOR0_BIT 24
`define GP_RESET_A_BIT 19
`define GP_RESET_B_BIT 18
`define GP_RESET_C_BIT 17
`define GP_RESET_D_BIT 16
`define TWO_WIRE0_BIT 12
`define QUAD_ENCODER0_BIT 8
`define SYNC_SERIAL0_BIT 4
`define ASYNC_SERIAL2_BIT 2
`define ASYNC_SERIAL1_BIT 1
`define ASYNC_SERIAL0_BIT 0

// Implemented bits; everything else is reserved, read-only zero
`define PERIPH_RESET_CTL_B_WMASK 32'h010f_1117

// Answer to an unmapped read
`define UNMAPPED_RDATA 32'h0000_0000

`endif

/* File: logic/reset_bank_pkg.sv */
package reset_bank_pkg;

  // Bus slave sequencing, one-hot
  typedef enum logic [1:0] {
    SLV_IDLE = 2'b01,
    SLV_DONE = 2'b10
  } slave_state_t;

  // Peripheral reset word
  typedef logic [31:0] reset_word_t;

endpackage : reset_bank_pkg

/* File: logic/reg_access_if.sv */
`timescale 1ns/100ps

// Register access between bus slave and register bank
interface reg_access_if;
  logic wr_en;
  logic [31:0] wdata;
  logic hit;
  logic [31:0] rdata;

  modport slave (output wr_en, output wdata, output hit, input rdata);
  modport bank (input wr_en, input wdata, input hit, output rdata);
endinterface : reg_access_if

/* File: logic/apb_reg_port.sv */
`timescale 1ns/100ps
`include "reset_bank_defines.svh"

module apb_reg_port
  import reset_bank_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Register side
  reg_access_if.slave regs
);

  slave_state_t state_q;
  logic access;
  logic hit;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign access = psel & penable;
  assign hit = (paddr == `PERIPH_RESET_CTL_B_OFFSET);
  assign regs.hit = hit;
  assign regs.wdata = pwdata;
  // Write lands on the edge where pready is sampled high; bank qualifies with hit
  assign regs.wr_en = access & pwrite & (state_q == SLV_DONE);

  ////////////////////////////////////////////////////////////////////////
  // One wait state, then answer for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= SLV_IDLE;
    end
    else
    begin
      case (state_q)
        SLV_IDLE: if (access) state_q <= SLV_DONE;
        SLV_DONE: state_q <= SLV_IDLE;
        default: state_q <= SLV_IDLE;
      endcase
    end
  end

  // Registered answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'h0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'h0;
    end
    else
    begin
      pready <= access & (state_q == SLV_IDLE);
      pslverr <= access & (state_q == SLV_IDLE) & ~hit;
      if (access & (state_q == SLV_IDLE) & ~pwrite)
        prdata <= hit ? regs.rdata : `UNMAPPED_RDATA;
    end
  end

endmodule : apb_reg_port

/* File: logic/peripheral_soft_reset_bank.sv */
`timescale 1ns/100ps
`include "reset_bank_defines.svh"

module peripheral_soft_reset_bank
  import reset_bank_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Device capability bits, one per peripheral
  input wire reset_bank_pkg::reset_word_t capability_mask_b,
  // Peripheral resets, active high
  output logic comparator0_reset,
  output logic gp_reset_a,
  output logic gp_reset_b,
  output logic gp_reset_c,
  output logic gp_reset_d,
  output logic two_wire0_reset,
  output logic quad_encoder0_reset,
  output logic sync_serial0_reset,
  output logic async_serial2_reset,
  output logic async_serial1_reset,
  output logic async_serial0_reset
);

  import reset_bank_pkg::*;

  reg_access_if regs ();

  reset_word_t readback;
  logic write_hit;

  ////////////////////////////////////////////////////////////////////////
  // Bits a write may touch: implemented and present
  function automatic reset_word_t writable(input reset_word_t cap);
    writable = cap & `PERIPH_RESET_CTL_B_WMASK;
  endfunction : writable

  // Visible value: reserved positions forced to zero
  function automatic reset_word_t visible(input reset_word_t word);
    visible = word & `PERIPH_RESET_CTL_B_WMASK;
  endfunction : visible

  // True when this write may change the bit at pos
  function automatic logic bit_write(input logic wr, input reset_word_t cap,
    input int unsigned pos);
    reset_word_t allowed;
    allowed = writable(cap);
    bit_write = wr & allowed[pos];
  endfunction : bit_write

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  apb_reg_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .regs(regs.slave)
  );

  ////////////////////////////////////////////////////////////////////////
  // Accepted write to the mapped control word
  assign write_hit = regs.wr_en & regs.hit;

  ////////////////////////////////////////////////////////////////////////
  // One flop per peripheral reset; a one holds the unit in reset

  // Analog comparator 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comparator0_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `COMPARATOR0_BIT))
    begin
      comparator0_reset <= regs.wdata[`COMPARATOR0_BIT];
    end
  end

  // Timer 3
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_reset_a <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `GP_RESET_A_BIT))
    begin
      gp_reset_a <= regs.wdata[`GP_RESET_A_BIT];
    end
  end

  // Timer 2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_reset_b <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `GP_RESET_B_BIT))
    begin
      gp_reset_b <= regs.wdata[`GP_RESET_B_BIT];
    end
  end

  // Timer 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_reset_c <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `GP_RESET_C_BIT))
    begin
      gp_reset_c <= regs.wdata[`GP_RESET_C_BIT];
    end
  end

  // Timer 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_reset_d <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `GP_RESET_D_BIT))
    begin
      gp_reset_d <= regs.wdata[`GP_RESET_D_BIT];
    end
  end

  // Two-wire serial unit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      two_wire0_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `TWO_WIRE0_BIT))
    begin
      two_wire0_reset <= regs.wdata[`TWO_WIRE0_BIT];
    end
  end

  // Quadrature encoder unit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quad_encoder0_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `QUAD_ENCODER0_BIT))
    begin
      quad_encoder0_reset <= regs.wdata[`QUAD_ENCODER0_BIT];
    end
  end

  // Synchronous serial unit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_serial0_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `SYNC_SERIAL0_BIT))
    begin
      sync_serial0_reset <= regs.wdata[`SYNC_SERIAL0_BIT];
    end
  end

  // Async serial unit 2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_serial2_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `ASYNC_SERIAL2_BIT))
    begin
      async_serial2_reset <= regs.wdata[`ASYNC_SERIAL2_BIT];
    end
  end

  // Async serial unit 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_serial1_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `ASYNC_SERIAL1_BIT))
    begin
      async_serial1_reset <= regs.wdata[`ASYNC_SERIAL1_BIT];
    end
  end

  // Async serial unit 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_serial0_reset <= 1'h0;
    end
    else if (bit_write(write_hit, capability_mask_b, `ASYNC_SERIAL0_BIT))
    begin
      async_serial0_reset <= regs.wdata[`ASYNC_SERIAL0_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback word; positions without a flop stay zero
  always_comb
  begin
    readback = `PERIPH_RESET_CTL_B_RESET;
    readback[`COMPARATOR0_BIT] = comparator0_reset;
    readback[`GP_RESET_A_BIT] = gp_reset_a;
    readback[`GP_RESET_B_BIT] = gp_reset_b;
    readback[`GP_RESET_C_BIT] = gp_reset_c;
    readback[`GP_RESET_D_BIT] = gp_reset_d;
    readback[`TWO_WIRE0_BIT] = two_wire0_reset;
    readback[`QUAD_ENCODER0_BIT] = quad_encoder0_reset;
    readback[`SYNC_SERIAL0_BIT] = sync_serial0_reset;
    readback[`ASYNC_SERIAL2_BIT] = async_serial2_reset;
    readback[`ASYNC_SERIAL1_BIT] = async_serial1_reset;
    readback[`ASYNC_SERIAL0_BIT] = async_serial0_reset;
  end

  // Reserved positions forced to zero on the bus
  assign regs.rdata = visible(readback);

endmodule : peripheral_soft_reset_bank

/* File: sim/periph_resets.sv */
`timescale 1ns/100ps
// Reset inputs of the peripherals, gathered into one word
module periph_resets (
  // Reset lines
  input wire logic c24, t19, t18, t17, t16, w12, q8, s4, a2, a1, a0,
  // Held-in-reset view
  output logic [31:0] held
);
  // A unit sits in reset while its line is high
  assign held = {7'h0, c24, 4'h0, t19, t18, t17, t16, 3'h0, w12, 3'h0, q8, 3'h0, s4, 1'h0,
    a2, a1, a0};
endmodule : periph_resets

/* File: sim/reset_bank_properties.sv */
`timescale 1ns/100ps
`include "reset_bank_defines.svh"
module reset_bank_properties (
  // Bus
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata, capability_mask_b,
  // Resets
  input wire logic comparator0_reset, gp_reset_d, async_serial0_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfers
  wire wr = pready && pwrite && paddr == 12'h044;
  wire rd = pready && !pwrite;
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready) else $error("late ready");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("long ready");
  a_err_addr:
    assert property (pready |-> pslverr == (paddr != 12'h044)) else $error("bad pslverr");
  a_comp_write:
    assert property (wr |=> comparator0_reset == ($past(capability_mask_b[24]) ?
      $past(pwdata[24]) : $past(comparator0_reset))) else $error("bit 24 write");
  a_timer_write:
    assert property (wr |=> gp_reset_d == ($past(capability_mask_b[16]) ?
      $past(pwdata[16]) : $past(gp_reset_d))) else $error("bit 16 write");
  a_reserved_zero:
    assert property (rd |-> (prdata & ~`PERIPH_RESET_CTL_B_WMASK) == 0) else $error("reserved");
  a_read_bit:
    assert property (rd && !pslverr |-> prdata[0] == async_serial0_reset) else $error("bit 0");
  a_err_data:
    assert property (rd && pslverr |-> prdata == 0) else $error("unmapped data");
  a_hold_quiet:
    assert property (!wr |=> $stable(async_serial0_reset)) else $error("stray change");
  cover property (wr);
  cover property (rd && pslverr);
  cover property (wr && capability_mask_b == 0);
endmodule : reset_bank_properties
bind peripheral_soft_reset_bank reset_bank_properties i_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .capability_mask_b,
  .comparator0_reset, .gp_reset_d, .async_serial0_reset);

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`include "reset_bank_defines.svh"
module testbench;
  import reset_bank_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  reset_word_t pwdata = 0, cap = 0, prdata, held, exp_w = 0, m = `PERIPH_RESET_CTL_B_WMASK;
  wire [10:0] r;
  logic [65:0] notes[$], n;
  int bad_count = 0, comparisons = 0, cyc = 0;
  peripheral_soft_reset_bank i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .capability_mask_b(cap), .comparator0_reset(r[10]),
    .gp_reset_a(r[9]), .gp_reset_b(r[8]), .gp_reset_c(r[7]), .gp_reset_d(r[6]),
    .two_wire0_reset(r[5]), .quad_encoder0_reset(r[4]), .sync_serial0_reset(r[3]),
    .async_serial2_reset(r[2]), .async_serial1_reset(r[1]), .async_serial0_reset(r[0]));
  periph_resets i_far (.c24(r[10]), .t19(r[9]), .t18(r[8]), .t17(r[7]), .t16(r[6]),
    .w12(r[5]), .q8(r[4]), .s4(r[3]), .a2(r[2]), .a1(r[1]), .a0(r[0]), .held);
  always #12.5 pclk = ~pclk;
  task summarize;
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", s, e, g);
      bad_count++;
    end
  endtask : chk
  // One APB transfer; the expected answer goes to the queue first
  task acc(logic w, logic [11:0] a, logic [31:0] d);
    logic e;
    @(posedge pclk);
    e = a != 12'h044;
    if (w && !e) exp_w = (d & cap & m) | (exp_w & ~(cap & m));
    notes.push_back({!w, e, e ? 32'h0 : exp_w, exp_w});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk iff pready);
    psel <= 0;
    penable <= 0;
  endtask : acc
  // Answer checker and run limit
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      summarize();
    end
    else if (presetn && pready)
    begin
      n = notes.pop_front();
      chk("pslverr", {31'h0, n[64]}, {31'h0, pslverr});
      if (n[65]) chk("prdata", n[63:32], prdata);
      if (n[65] && !n[64]) chk("held", n[31:0], held);
    end
  end
  initial
  begin
    void'($urandom(32'h6ef6));
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 2; k++)
    begin
      presetn <= 1;
      exp_w = 0;
      acc(0, 12'h044, 0);
      cap <= '1;
      acc(1, 12'h044, '1);
      acc(0, 12'h044, 0);
      acc(1, 12'h048, 0);
      acc(0, 12'h040, 0);
      for (int i = 0; i < 30; i++)
      begin
        cap <= (i % 5 == 0) ? 32'h0 : $urandom;
        @(posedge pclk);
        acc(1, 12'h044, $urandom);
        acc(0, 12'h044, 0);
      end
      @(posedge pclk);
      presetn <= 0;
      @(posedge pclk);
    end
    summarize();
  end
endmodule : testbench
